// *** rtl/bbs_rx_status_regs.sv ***
// Rx and gain status registers of the baseband, with writable mux and lock window, on classic Wishbone.
// Assumes a single-clock Wishbone master and datapath inputs on clk_sys.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "bbs_regs.svh"

module bbs_rx_status_regs #(
   parameter int ADR_W = 10
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire bbs_pkg::bbs_agc_in_t agcIn,
   input wire bbs_pkg::bbs_meas_in_t measIn,
   input wire bbs_pkg::bbs_hdr_ev_t hdrEv,
   output logic gainLoopLocked
);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // Picks the a or b value of a read-only field
   function automatic logic [7:0] setPick(
      input logic selA,
      input logic [7:0] valA,
      input logic [7:0] valB
   );
      setPick = selA ? valA : valB;
   endfunction

   // Level inside inclusive window of 4-bit coarse codes
   function automatic logic inWindow(
      input logic [6:0] level,
      input logic [7:0] win
   );
      logic [3:0] coarse;
      // Coarse codes keep both window bounds in one byte
      coarse = level[6:3];
      inWindow = (coarse >= win[`BBS_LOCK_LO_MSB:`BBS_LOCK_LO_LSB])
         && (coarse <= win[`BBS_LOCK_HI_MSB:`BBS_LOCK_HI_LSB]);
   endfunction

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic ack;
   logic [31:0] rdData;
   logic next_ack;
   logic [31:0] next_rdData;
   logic [7:0] muxCtrl;
   logic [7:0] lockWin;
   logic [7:0] next_muxCtrl;
   logic [7:0] next_lockWin;
   logic [7:0] txPwr;
   logic txFresh;
   logic [7:0] next_txPwr;
   logic next_txFresh;
   logic [7:0] sigStrength;
   logic [7:0] next_sigStrength;
   logic [7:0] agcStat;
   logic [7:0] next_agcStat;
   bbs_pkg::bbs_hdr_stat_t hdrStat;
   logic req;
   logic [7:0] idx;
   logic wbDone;
   logic wrLow;
   logic rdTxPwr;
   logic selA;
   logic [7:0] agcValA;
   logic [7:0] agcValB;
   logic [7:0] hdrValA;
   logic [7:0] hdrValB;
   logic [7:0] sigValA;
   logic [7:0] sigValB;
   logic [7:0] txValA;
   logic [7:0] txValB;

   // ----------------------------------------
   // Header capture
   // ----------------------------------------
   // Capture runs every edge; the read mux only picks its bits
   bbs_hdr_capture uCapture (
      .clk_sys(clk_sys),
      .srst(srst),
      .hdrEv(hdrEv),
      .hdrStat(hdrStat)
   );

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   // Ack on the cycle after the strobe, dropped the next
   assign req = cyc_i && stb_i && !ack;
   assign idx = adr_i[9:2];

   // ----------------------------------------
   // Bus completion
   // ----------------------------------------
   // Side effects wait for the edge at which the master sees ack high,
   // so a write or a clearing read never lands before the cycle ends
   assign wbDone = cyc_i && stb_i && ack;
   // Byte lanes above the low one carry no register bits
   assign wrLow = wbDone && we_i && sel_i[0];
   assign rdTxPwr = wbDone && !we_i && (idx == `BBS_IDX_TX_PWR);

   // ----------------------------------------
   // Writable configuration
   // ----------------------------------------
   always_comb begin
      next_muxCtrl = muxCtrl;
      next_lockWin = lockWin;
      // Mux bits 6:0 are plain storage with no effect in this bank
      if (wrLow && (idx == `BBS_IDX_MUX_CTRL)) begin
         next_muxCtrl = dat_i[7:0];
      end
      if (wrLow && (idx == `BBS_IDX_LOCK_WIN)) begin
         next_lockWin = dat_i[7:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         muxCtrl <= `BBS_MUX_CTRL_RST;
         lockWin <= `BBS_LOCK_WIN_RST;
      end else begin
         muxCtrl <= next_muxCtrl;
         lockWin <= next_lockWin;
      end
   end

   // ----------------------------------------
   // Transmit power measurement
   // ----------------------------------------
   always_comb begin
      // A read returns the old flag; the clear lands as it completes
      next_txPwr = txPwr;
      next_txFresh = txFresh;
      if (rdTxPwr) begin
         next_txFresh = 1'b0;
      end
      // new value sets, wins over read
      if (measIn.txPowerUpdate) begin
         next_txPwr = measIn.txPower;
         next_txFresh = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         txPwr <= `BBS_BYTE_RST;
         txFresh <= 1'b0;
      end else begin
         txPwr <= next_txPwr;
         txFresh <= next_txFresh;
      end
   end

   // ----------------------------------------
   // Live status sampling
   // ----------------------------------------
   // One register stage so readback is glitch free
   always_comb begin
      next_agcStat = 8'h00;
      next_agcStat[`BBS_AGC_ENERGY_BIT] = agcIn.energyOverThreshold;
      // Next value, so the bit has no extra cycle of lag
      // freshness bit
      next_agcStat[`BBS_AGC_FRESH_BIT] = next_txFresh;
      next_agcStat[`BBS_GAIN_LOOP_LOCKED_BIT] = inWindow(agcIn.agcLevel, lockWin);
      next_agcStat[`BBS_AGC_RAIL_BIT] = agcIn.gainRailHalt;
      next_agcStat[`BBS_AGC_RFOUT_BIT] = agcIn.rfGainOutState;
      // Unsigned byte passed straight through
      // packet strength byte
      next_sigStrength = measIn.signalStrength;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         agcStat <= `BBS_BYTE_RST;
         sigStrength <= `BBS_BYTE_RST;
      end else begin
         agcStat <= next_agcStat;
         sigStrength <= next_sigStrength;
      end
   end

   // Exported lock follows the registered bit, not the raw compare
   assign gainLoopLocked = agcStat[`BBS_GAIN_LOOP_LOCKED_BIT];

   // ----------------------------------------
   // Value sets
   // ----------------------------------------
   // Every field here is common to both sets, so a and b share sources
   assign selA = muxCtrl[`BBS_MUX_SEL_BIT];
   assign agcValA = agcStat;
   assign agcValB = agcStat;
   assign sigValA = sigStrength;
   assign sigValB = sigStrength;
   assign txValA = txPwr;
   assign txValB = txPwr;

   // ----------------------------------------
   // Header status byte
   // ----------------------------------------
   // Bit 0 stays zero; rate and antenna outlive a packet start
   always_comb begin
      hdrValA = 8'h00;
      hdrValA[`BBS_HDR_RATE_MSB:`BBS_HDR_RATE_LSB] = hdrStat.rate;
      hdrValA[`BBS_HDR_SFD_BIT] = hdrStat.sfdFound;
      hdrValA[`BBS_HDR_SHORT_BIT] = hdrStat.shortPreamble;
      hdrValA[`BBS_HDR_SIGVALID_BIT] = hdrStat.sigValid;
      hdrValA[`BBS_HDR_CRC_BIT] = hdrStat.crcOk;
      hdrValA[`BBS_HDR_ANT_BIT] = hdrStat.antenna;
      // Both sets show the same header fields
      hdrValB = hdrValA;
   end

   // ----------------------------------------
   // Read mux and acknowledge
   // ----------------------------------------
   always_comb begin
      next_ack = req;
      next_rdData = rdData;
      if (req) begin
         // Writes answer with zero data
         next_rdData = `BBS_WORD_ZERO;
         if (!we_i) begin
            unique case (idx)
               `BBS_IDX_MUX_CTRL: begin
                  next_rdData[7:0] = muxCtrl;
               end
               `BBS_IDX_LOCK_WIN: begin
                  next_rdData[7:0] = lockWin;
               end
               `BBS_IDX_TX_PWR: begin
                  next_rdData[7:0] = setPick(selA, txValA, txValB);
               end
               `BBS_IDX_AGC_STATUS: begin
                  next_rdData[7:0] = setPick(selA, agcValA, agcValB);
               end
               `BBS_IDX_SIG_STRENGTH: begin
                  next_rdData[7:0] = setPick(selA, sigValA, sigValB);
               end
               `BBS_IDX_HDR_STATUS: begin
                  next_rdData[7:0] = setPick(selA, hdrValA, hdrValB);
               end
               // Unmapped reads answer zero rather than stalling the bus
               default: begin
                  next_rdData = `BBS_WORD_ZERO;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ack <= 1'b0;
         rdData <= `BBS_WORD_ZERO;
      end else begin
         ack <= next_ack;
         rdData <= next_rdData;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Both come straight from flops, so no decode glitch reaches the bus
   assign ack_o = ack;
   assign dat_o = rdData;

endmodule

// *** rtl/bbs_regs.svh ***
// Register indices, field positions, reset values for the rx status bank.
// Assumes the includer maps each index to byte address index * 4.
`ifndef BBS_REGS_SVH
`define BBS_REGS_SVH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define BBS_IDX_LOCK_WIN 8'h28
`define BBS_IDX_MUX_CTRL 8'h62
`define BBS_IDX_TX_PWR 8'h74
`define BBS_IDX_AGC_STATUS 8'h7C
`define BBS_IDX_SIG_STRENGTH 8'h7E
`define BBS_IDX_HDR_STATUS 8'h80

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BBS_MUX_SEL_BIT 7
`define BBS_AGC_ENERGY_BIT 4
`define BBS_AGC_FRESH_BIT 3
`define BBS_GAIN_LOOP_LOCKED_BIT 2
`define BBS_AGC_RAIL_BIT 1
`define BBS_AGC_RFOUT_BIT 0
`define BBS_HDR_RATE_MSB 7
`define BBS_HDR_RATE_LSB 6
`define BBS_HDR_SFD_BIT 5
`define BBS_HDR_SHORT_BIT 4
`define BBS_HDR_SIGVALID_BIT 3
`define BBS_HDR_CRC_BIT 2
`define BBS_HDR_ANT_BIT 1
`define BBS_LOCK_HI_MSB 7
`define BBS_LOCK_HI_LSB 4
`define BBS_LOCK_LO_MSB 3
`define BBS_LOCK_LO_LSB 0

// ----------------------------------------
// Rate codes and reset values
// ----------------------------------------
`define BBS_RATE_1M 2'h0
`define BBS_RATE_2M 2'h1
`define BBS_RATE_5M5 2'h2
`define BBS_RATE_11M 2'h3
`define BBS_MUX_CTRL_RST 8'h00
`define BBS_LOCK_WIN_RST 8'hF0
`define BBS_BYTE_RST 8'h00
`define BBS_WORD_ZERO 32'h0000_0000

`endif

// *** rtl/bbs_pkg.sv ***
// Types carried between the rx status bank and the modem datapath.
// Assumes all signals are synchronous to clk_sys.
package bbs_pkg;

   // ----------------------------------------
   // Gain loop inputs
   // ----------------------------------------
   typedef struct packed {
      logic energyOverThreshold;
      logic gainRailHalt;
      logic rfGainOutState;
      logic [6:0] agcLevel;
   } bbs_agc_in_t;

   // ----------------------------------------
   // Measurement inputs
   // ----------------------------------------
   typedef struct packed {
      logic txPowerUpdate;
      logic [7:0] txPower;
      logic [7:0] signalStrength;
   } bbs_meas_in_t;

   // ----------------------------------------
   // Header decoder events
   // ----------------------------------------
   typedef struct packed {
      logic rxStart;
      logic sfdFound;
      logic shortPreamble;
      logic sigFieldValid;
      logic [1:0] rateCode;
      logic crcPass;
      logic antennaSel;
   } bbs_hdr_ev_t;

   // ----------------------------------------
   // Captured header status
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] rate;
      logic sfdFound;
      logic shortPreamble;
      logic sigValid;
      logic crcOk;
      logic antenna;
   } bbs_hdr_stat_t;

endpackage

// *** rtl/bbs_hdr_capture.sv ***
// Captures per-packet header status from decoder event pulses.
// Assumes event pulses are one clk_sys cycle wide.
`timescale 1ns/10ps
`include "bbs_regs.svh"

module bbs_hdr_capture (
   input wire logic clk_sys,
   input wire logic srst,
   input wire bbs_pkg::bbs_hdr_ev_t hdrEv,
   output bbs_pkg::bbs_hdr_stat_t hdrStat
);

   bbs_pkg::bbs_hdr_stat_t stat;
   bbs_pkg::bbs_hdr_stat_t next_stat;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_stat = stat;
      // Packet start clears flags; a same-cycle event still sets
      if (hdrEv.rxStart) begin
         next_stat.sfdFound = 1'b0;
         next_stat.shortPreamble = 1'b0;
         next_stat.sigValid = 1'b0;
         next_stat.crcOk = 1'b0;
      end
      if (hdrEv.sfdFound) begin
         next_stat.sfdFound = 1'b1;
         next_stat.shortPreamble = hdrEv.shortPreamble;
      end
      if (hdrEv.sigFieldValid) begin
         next_stat.sigValid = 1'b1;
         next_stat.rate = hdrEv.rateCode;
      end
      if (hdrEv.crcPass) begin
         next_stat.crcOk = 1'b1;
         next_stat.antenna = hdrEv.antennaSel;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         stat <= '0;
      end else begin
         stat <= next_stat;
      end
   end

   assign hdrStat = stat;

endmodule

// *** tb/bbs_rx_status_regs_sva.sv ***
// Port assertions for the rx status bank.
// Assumes it is bound into bbs_rx_status_regs.
`timescale 1ns/10ps
`include "bbs_regs.svh"
module bbs_rx_status_regs_sva #(
   parameter int ADR_W = 10
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire bbs_pkg::bbs_agc_in_t agcIn,
   input wire bbs_pkg::bbs_meas_in_t measIn,
   input wire bbs_pkg::bbs_hdr_ev_t hdrEv
);
   logic up1;
   logic up2;
   logic rdAck;
   logic agcRd;
   logic hdrRd;
   // Two clean edges needed before $past depth 2 is trusted
   always_ff @(posedge clk_sys) begin
      up1 <= !srst;
      up2 <= up1 && !srst;
   end
   assign rdAck = ack_o && !we_i && up2;
   assign agcRd = rdAck && adr_i[9:2] == `BBS_IDX_AGC_STATUS;
   assign hdrRd = rdAck && adr_i[9:2] == `BBS_IDX_HDR_STATUS;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   AST_ACK_ONE: assert property (ack_o |=> !ack_o)
      else $error("ack wider than one cycle");
   AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not acked next cycle");
   AST_WR_ZERO: assert property (ack_o && we_i |-> dat_o == 32'h0)
      else $error("write ack data not zero");
   AST_ENERGY: assert property (agcRd |-> dat_o[4] == $past(agcIn.energyOverThreshold, 2))
      else $error("energy bit wrong");
   AST_FRESH: assert property (agcRd && $past(measIn.txPowerUpdate, 2) |-> dat_o[3])
      else $error("fresh bit not set");
   AST_RAIL: assert property (agcRd |-> dat_o[1] == $past(agcIn.gainRailHalt, 2))
      else $error("rail bit wrong");
   AST_RFOUT: assert property (agcRd |-> dat_o[0] == $past(agcIn.rfGainOutState, 2)
      && dat_o[7:5] == 3'h0) else $error("rf out or unused bits wrong");
   AST_SIG_STR: assert property (rdAck && adr_i[9:2] == `BBS_IDX_SIG_STRENGTH
      |-> dat_o[31:0] == {24'h0, $past(measIn.signalStrength, 2)})
      else $error("signal strength wrong");
   AST_RATE: assert property (hdrRd && $past(hdrEv.sigFieldValid, 2)
      |-> dat_o[3] && dat_o[7:6] == $past(hdrEv.rateCode, 2)) else $error("rate wrong");
   AST_SFD: assert property (hdrRd && $past(hdrEv.sfdFound, 2)
      |-> dat_o[5] && dat_o[4] == $past(hdrEv.shortPreamble, 2)) else $error("sfd wrong");
   AST_CRC: assert property (hdrRd && $past(hdrEv.crcPass, 2)
      |-> dat_o[2] && dat_o[1] == $past(hdrEv.antennaSel, 2) && !dat_o[0])
      else $error("crc or antenna wrong");
endmodule

// *** tb/bbs_wb_master.sv ***
// Classic Wishbone master standing in for host firmware.
// Assumes one clock; holds each request until ack is sampled high.
`timescale 1ns/10ps
module bbs_wb_master (
   input wire logic clk_sys,
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [9:0] adr,
   output logic [3:0] sel,
   output logic [31:0] dat,
   input wire logic ack
);
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 10'h0;
      sel = 4'h0;
      dat = 32'h0;
   end
   task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d,
      input logic [3:0] s);
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat <= {24'h0, d};
      @(posedge clk_sys);
      while (ack !== 1'b1) @(posedge clk_sys);
      cyc <= 1'b0;
      stb <= 1'b0;
      // Released address and data lines carry junk, never a stale value; we and sel keep theirs
      adr <= ~a;
      dat <= ~{24'h0, d};
   endtask
endmodule

// *** tb/test_baseband_rx_status_regs.sv ***
// Self-checking bench for the rx status bank.
// Assumes bbs_wb_master as bus partner and a 10 MHz clk_sys.
`timescale 1ns/10ps
`include "bbs_regs.svh"
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin err_count++; \
   $display("mismatch %s expected %h seen %h", nm, e, s); end end
module test_baseband_rx_status_regs;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic cyc;
   logic stb;
   logic we;
   logic [9:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic ack;
   logic locked;
   bbs_pkg::bbs_agc_in_t agcIn = '0;
   bbs_pkg::bbs_meas_in_t measIn = '0;
   bbs_pkg::bbs_hdr_ev_t hdrEv = '0;
   logic [31:0] expQ[$];
   logic [31:0] e;
   int err_count = 0;
   int samples_checked = 0;
   logic [7:0] v;
   logic [1:0] r;
   always #50 clk_sys = ~clk_sys;
   bbs_wb_master mst (.clk_sys(clk_sys), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
      .sel(sel), .dat(wdat), .ack(ack));
   bbs_rx_status_regs dut (.clk_sys(clk_sys), .srst(srst), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .agcIn(agcIn), .measIn(measIn), .hdrEv(hdrEv), .gainLoopLocked(locked));
   always @(posedge clk_sys) begin
      if (ack === 1'b1) begin
         `CHK("pending", 1'b1, expQ.size() != 0)
         e = (expQ.size() != 0) ? expQ.pop_front() : 32'hFFFF_FFFF;
         `CHK("rdat", e, rdat)
      end
   end
   task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d,
      input logic [7:0] x);
      expQ.push_back({24'h0, x});
      mst.xfer(w, {i, 2'b00}, d, 4'hF);
   endtask
   task automatic ev(input logic [7:0] p);
      @(posedge clk_sys);
      hdrEv <= p;
      @(posedge clk_sys);
      hdrEv <= '0;
   endtask
   // Pulse lands on the edge the read starts, so the checker sees it too
   task automatic hdrBurst(input logic [7:0] v);
      @(posedge clk_sys);
      hdrEv <= {2'b11, v[0], 1'b1, v[2:1], 1'b1, v[3]};
      fork
         acc(0, `BBS_IDX_HDR_STATUS, 0, {v[2:1], 1'b1, v[0], 2'b11, v[3], 1'b0});
         begin
            @(posedge clk_sys);
            hdrEv <= '0;
         end
      join
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk_sys);
      err_count++;
      end_of_test();
   end
   initial begin
      void'($urandom(32'h2476));
      repeat (8) @(posedge clk_sys);
      srst <= 1'b0;
      acc(0, `BBS_IDX_LOCK_WIN, 0, `BBS_LOCK_WIN_RST);
      acc(0, `BBS_IDX_AGC_STATUS, 0, 8'h04);
      acc(0, `BBS_IDX_HDR_STATUS, 0, 8'h00);
      acc(0, 8'hFF, 0, 8'h00);
      acc(1, `BBS_IDX_SIG_STRENGTH, 8'h5A, 8'h00);
      $display("test reset done");
      for (int m = 0; m < 2; m++) begin
         acc(1, `BBS_IDX_MUX_CTRL, 8'(m << 7), 8'h00);
         acc(0, `BBS_IDX_MUX_CTRL, 0, 8'(m << 7));
         repeat (3) begin
            v = 8'($urandom);
            @(posedge clk_sys);
            measIn.signalStrength <= v;
            acc(0, `BBS_IDX_SIG_STRENGTH, 0, v);
         end
      end
      $display("test mux done");
      for (int k = 0; k < 8; k++) begin
         @(posedge clk_sys);
         agcIn <= {k[2:0], 7'h0};
         acc(0, `BBS_IDX_AGC_STATUS, 0, {3'h0, k[2], 2'b01, k[1:0]});
      end
      acc(1, `BBS_IDX_LOCK_WIN, 8'h53, 8'h00);
      expQ.push_back(`BBS_WORD_ZERO);
      mst.xfer(1'b1, {`BBS_IDX_LOCK_WIN, 2'b00}, 8'h11, 4'hE);
      acc(0, `BBS_IDX_LOCK_WIN, 0, 8'h53);
      for (int k = 2; k < 7; k++) begin
         @(posedge clk_sys);
         agcIn <= {3'h0, k[3:0], 3'h5};
         v = {5'h0, (k >= 3 && k <= 5), 2'h0};
         acc(0, `BBS_IDX_AGC_STATUS, 0, v);
         `CHK("locked", v[2], locked)
      end
      $display("test gain done");
      v = 8'($urandom);
      @(posedge clk_sys);
      measIn.txPowerUpdate <= 1'b1;
      measIn.txPower <= v;
      fork
         acc(0, `BBS_IDX_AGC_STATUS, 0, 8'h08);
         begin
            @(posedge clk_sys);
            measIn.txPowerUpdate <= 1'b0;
         end
      join
      acc(0, `BBS_IDX_TX_PWR, 0, v);
      acc(0, `BBS_IDX_AGC_STATUS, 0, 8'h00);
      $display("test fresh done");
      for (int k = 0; k < 4; k++) begin
         r = 2'(k);
         ev(8'h80);
         ev({2'b01, r[0], 5'h0});
         ev({4'h1, r, 2'h0});
         ev({7'h1, r[1]});
         acc(0, `BBS_IDX_HDR_STATUS, 0, {r, 1'b1, r[0], 2'b11, r[1], 1'b0});
         ev(8'h80);
         acc(0, `BBS_IDX_HDR_STATUS, 0, {r, 4'h0, r[1], 1'b0});
      end
      $display("test header done");
      repeat (4) begin
         v = 8'($urandom);
         hdrBurst(v);
      end
      $display("test header burst done");
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      acc(0, `BBS_IDX_LOCK_WIN, 0, `BBS_LOCK_WIN_RST);
      acc(0, `BBS_IDX_MUX_CTRL, 0, `BBS_MUX_CTRL_RST);
      acc(0, `BBS_IDX_AGC_STATUS, 0, 8'h04);
      acc(0, `BBS_IDX_HDR_STATUS, 0, 8'h00);
      acc(0, `BBS_IDX_TX_PWR, 0, 8'h00);
      $display("test mid reset done");
      end_of_test();
   end
endmodule
bind bbs_rx_status_regs bbs_rx_status_regs_sva #(.ADR_W(ADR_W)) u_sva (.clk_sys(clk_sys),
   .srst(srst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
   .ack_o(ack_o), .agcIn(agcIn), .measIn(measIn), .hdrEv(hdrEv));
